// >>> shared/rtfc_pkg.sv
// package: register map, reset values and field layout of the trim/filter bank
// Notes on behaviour
// - amplifier bias trim in bits 6..1, resets to 55; 63 gives highest power
// - oscillator calibration skip field resets to 9 (run); 15 bypasses calibration
// - crystal load trim bits 5..3, resets 4; step of 187.5 fF per code
// - read-only band result bits 7..2 from latest calibration, zero after reset
// - read-only bias result from latest calibration, shares the band result address
// - first-stage decimation bits 1..0: rate 13 MHz / 2^code, resets to 1
// - second-stage decimation bits 4..2: rate first-stage / 2^code, resets to 1
// - post-demod bandwidth byte, code times 15 kHz, resets to 200
// - nine-bit tuning overwrite: low byte, msb at bit 0 next, enable bit 1
// - analog baseband bandwidth bits 3..0, resets to 13, codes 6..15 used
// - band/bias overwrite applies only with skip field 15 and its enable set
package rtfc_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [9:0] ADDR_AMP_BIAS    = 10'h36e;
   localparam logic [9:0] ADDR_CAL_SKIP    = 10'h36f;
   localparam logic [9:0] ADDR_XTAL_LOAD   = 10'h371;
   localparam logic [9:0] ADDR_OSC_RB      = 10'h381;
   localparam logic [9:0] ADDR_RX_DECIM    = 10'h389;
   localparam logic [9:0] ADDR_POST_DEMOD  = 10'h38b;
   localparam logic [9:0] ADDR_TUNE_LOW    = 10'h395;
   localparam logic [9:0] ADDR_TUNE_HIGH   = 10'h396;
   localparam logic [9:0] ADDR_RX_FE       = 10'h39b;

   // ****************************************
   // reset values (whole byte, reserved bits at default)
   // ****************************************
   localparam logic [7:0] RST_AMP_BIAS     = 8'h6f;
   localparam logic [7:0] RST_CAL_SKIP     = 8'h09;
   localparam logic [7:0] RST_XTAL_LOAD    = 8'h20;
   localparam logic [7:0] RST_RX_DECIM     = 8'h05;
   localparam logic [7:0] RST_POST_DEMOD   = 8'hc8;
   localparam logic [7:0] RST_TUNE_LOW     = 8'h00;
   localparam logic [7:0] RST_TUNE_HIGH    = 8'h08;
   localparam logic [7:0] RST_RX_FE        = 8'h1d;
   localparam logic [5:0] RST_OSC_RESULT   = 6'h00;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // ****************************************
   // field positions and codes
   // ****************************************
   localparam int AMP_BIAS_LSB    = 1;
   localparam int XTAL_LOAD_LSB   = 3;
   localparam int DECIM2_LSB      = 2;
   localparam int TUNE_MSB_BIT    = 0;
   localparam int TUNE_EN_BIT     = 1;
   localparam int LNA_SEL_BIT     = 4;
   localparam int OSC_RB_LSB      = 2;
   localparam logic [3:0] CAL_SKIP_BYPASS = 4'hf;

   // register access request from the control port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [9:0] addr;
      logic [7:0] wdata;
   } rtfc_req_s;

   // calibration result handed over by the radio controller
   typedef struct packed {
      logic       done;
      logic [5:0] band;
      logic [5:0] bias;
   } rtfc_cal_s;

   // field values steering the analog and filter sections
   typedef struct packed {
      logic [5:0] amp_bias_trim_code;
      logic [3:0] cal_skip_code;
      logic       cal_bypass;
      logic [2:0] crystal_load_code;
      logic [1:0] first_stage_decimation;
      logic [2:0] second_stage_decimation;
      logic [7:0] post_demod_bw_code;
      logic [8:0] rx_tune_word;
      logic       rx_tune_en;
      logic       lna_sel;
      logic [3:0] analog_baseband_bw_code;
   } rtfc_cfg_s;

endpackage : rtfc_pkg

// >>> hdl/rtfc_byte_reg.sv
// one byte-wide read/write register with a parameter reset value
`timescale 1ns/1ns
`default_nettype none
module rtfc_byte_reg
   import rtfc_pkg::*;
#(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input  wire logic       sys_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       wr_en_in,
   input  wire logic [7:0] wdata_in,
   output var  logic [7:0] value_out
);

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         value_out <= RESET_VALUE;
      end else if (wr_en_in) begin
         value_out <= wdata_in;
      end
   end

endmodule : rtfc_byte_reg
`default_nettype wire

// >>> hdl/rtfc_bank.sv
// trim and receive filter configuration bank with calibration readback
`timescale 1ns/1ns
`default_nettype none
module rtfc_bank
   import rtfc_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       sys_rst_in,
   input  wire rtfc_req_s  req_in,
   output var  logic [7:0] rdata_out,
   output var  logic       rvalid_out,
   input  wire logic       rb_bias_sel_in,
   input  wire rtfc_cal_s  cal_in,
   input  wire logic [5:0] band_ovrw_val_in,
   input  wire logic       band_ovrw_en_in,
   input  wire logic [5:0] bias_ovrw_val_in,
   input  wire logic       bias_ovrw_en_in,
   output var  logic [5:0] osc_band_out,
   output var  logic [5:0] osc_bias_out,
   output var  rtfc_cfg_s  cfg_out
);

   // ****************************************
   // address decode
   // ****************************************
   // decoded once, shared by the write enables and the read select
   wire logic hit_amp_bias   = (req_in.addr == ADDR_AMP_BIAS);
   wire logic hit_cal_skip   = (req_in.addr == ADDR_CAL_SKIP);
   wire logic hit_xtal_load  = (req_in.addr == ADDR_XTAL_LOAD);
   wire logic hit_osc_rb     = (req_in.addr == ADDR_OSC_RB);
   wire logic hit_rx_decim   = (req_in.addr == ADDR_RX_DECIM);
   wire logic hit_post_demod = (req_in.addr == ADDR_POST_DEMOD);
   wire logic hit_tune_low   = (req_in.addr == ADDR_TUNE_LOW);
   wire logic hit_tune_high  = (req_in.addr == ADDR_TUNE_HIGH);
   wire logic hit_rx_fe      = (req_in.addr == ADDR_RX_FE);
   wire logic hit_any        = hit_amp_bias | hit_cal_skip | hit_xtal_load | hit_osc_rb
                             | hit_rx_decim | hit_post_demod | hit_tune_low | hit_tune_high
                             | hit_rx_fe;

   // ****************************************
   // write decode
   // ****************************************
   // the readback offset has no enable, so writes there and to holes are dropped
   wire logic we_amp_bias   = req_in.wr && hit_amp_bias;
   wire logic we_cal_skip   = req_in.wr && hit_cal_skip;
   wire logic we_xtal_load  = req_in.wr && hit_xtal_load;
   wire logic we_rx_decim   = req_in.wr && hit_rx_decim;
   wire logic we_post_demod = req_in.wr && hit_post_demod;
   wire logic we_tune_low   = req_in.wr && hit_tune_low;
   wire logic we_tune_high  = req_in.wr && hit_tune_high;
   wire logic we_rx_fe      = req_in.wr && hit_rx_fe;

   logic [7:0] amp_bias;
   logic [7:0] cal_skip;
   logic [7:0] xtal_load;
   logic [7:0] rx_decim;
   logic [7:0] post_demod;
   logic [7:0] tune_low;
   logic [7:0] tune_high;
   logic [7:0] rx_fe;

   // ****************************************
   // storage; reserved bits are stored as written, software keeps defaults
   // ****************************************
   // a write and a read of one offset in one cycle return the old byte
   rtfc_byte_reg #(.RESET_VALUE(RST_AMP_BIAS)) u_amp_bias (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .wr_en_in   (we_amp_bias),
      .wdata_in   (req_in.wdata),
      .value_out  (amp_bias)
   );
   rtfc_byte_reg #(.RESET_VALUE(RST_CAL_SKIP)) u_cal_skip (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .wr_en_in   (we_cal_skip),
      .wdata_in   (req_in.wdata),
      .value_out  (cal_skip)
   );
   rtfc_byte_reg #(.RESET_VALUE(RST_XTAL_LOAD)) u_xtal_load (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .wr_en_in   (we_xtal_load),
      .wdata_in   (req_in.wdata),
      .value_out  (xtal_load)
   );
   rtfc_byte_reg #(.RESET_VALUE(RST_RX_DECIM)) u_rx_decim (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .wr_en_in   (we_rx_decim),
      .wdata_in   (req_in.wdata),
      .value_out  (rx_decim)
   );
   rtfc_byte_reg #(.RESET_VALUE(RST_POST_DEMOD)) u_post_demod (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .wr_en_in   (we_post_demod),
      .wdata_in   (req_in.wdata),
      .value_out  (post_demod)
   );
   rtfc_byte_reg #(.RESET_VALUE(RST_TUNE_LOW)) u_tune_low (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .wr_en_in   (we_tune_low),
      .wdata_in   (req_in.wdata),
      .value_out  (tune_low)
   );
   rtfc_byte_reg #(.RESET_VALUE(RST_TUNE_HIGH)) u_tune_high (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .wr_en_in   (we_tune_high),
      .wdata_in   (req_in.wdata),
      .value_out  (tune_high)
   );
   rtfc_byte_reg #(.RESET_VALUE(RST_RX_FE)) u_rx_fe (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .wr_en_in   (we_rx_fe),
      .wdata_in   (req_in.wdata),
      .value_out  (rx_fe)
   );

   // ****************************************
   // calibration results
   // ****************************************
   logic [5:0] band_result;
   logic [5:0] bias_result;
   // band and bias move together so a read never mixes two calibrations

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         band_result <= RST_OSC_RESULT;
         bias_result <= RST_OSC_RESULT;
      end else if (cal_in.done) begin
         band_result <= cal_in.band;
         bias_result <= cal_in.bias;
      end
   end

   // ****************************************
   // field extraction
   // ****************************************
   wire logic cal_bypass = (cal_skip[3:0] == CAL_SKIP_BYPASS);

   // overwrite needs both the bypass code and its own enable
   // it steers the outputs only; the stored results stay readable
   wire logic band_ovrw_active = cal_bypass && band_ovrw_en_in;
   wire logic bias_ovrw_active = cal_bypass && bias_ovrw_en_in;
   wire logic [5:0] next_osc_band = band_ovrw_active ? band_ovrw_val_in : band_result;
   wire logic [5:0] next_osc_bias = bias_ovrw_active ? bias_ovrw_val_in : bias_result;

   rtfc_cfg_s next_cfg;
   // tune word halves act as each byte lands; nothing stages the pair
   assign next_cfg.amp_bias_trim_code      = amp_bias[AMP_BIAS_LSB +: 6];
   assign next_cfg.cal_skip_code           = cal_skip[3:0];
   assign next_cfg.cal_bypass              = cal_bypass;
   assign next_cfg.crystal_load_code       = xtal_load[XTAL_LOAD_LSB +: 3];
   assign next_cfg.first_stage_decimation  = rx_decim[1:0];
   assign next_cfg.second_stage_decimation = rx_decim[DECIM2_LSB +: 3];
   assign next_cfg.post_demod_bw_code      = post_demod;
   assign next_cfg.rx_tune_word            = {tune_high[TUNE_MSB_BIT], tune_low};
   assign next_cfg.rx_tune_en              = tune_high[TUNE_EN_BIT];
   assign next_cfg.lna_sel                 = rx_fe[LNA_SEL_BIT];
   assign next_cfg.analog_baseband_bw_code = rx_fe[3:0];

   // ****************************************
   // read mux
   // ****************************************
   // both readbacks share one address; a side input picks which one answers
   wire logic [5:0] osc_rb_field = rb_bias_sel_in ? bias_result : band_result;

   // one-hot and-or select: no priority chain, a hole reads the unmapped value
   wire logic [7:0] next_rdata = ({8{hit_amp_bias}}   & amp_bias)
                               | ({8{hit_cal_skip}}   & cal_skip)
                               | ({8{hit_xtal_load}}  & xtal_load)
                               | ({8{hit_osc_rb}}     & {osc_rb_field, 2'b00})
                               | ({8{hit_rx_decim}}   & rx_decim)
                               | ({8{hit_post_demod}} & post_demod)
                               | ({8{hit_tune_low}}   & tune_low)
                               | ({8{hit_tune_high}}  & tune_high)
                               | ({8{hit_rx_fe}}      & rx_fe)
                               | ({8{!hit_any}}       & READ_UNMAPPED);

   // ****************************************
   // output registers
   // ****************************************
   // outputs registered so the analog side never sees decode glitches
   // rdata_out holds between reads; the readback select is sampled with rd
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         rdata_out  <= READ_UNMAPPED;
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= req_in.rd;
         if (req_in.rd) begin
            rdata_out <= next_rdata;
         end
      end
   end

   // one edge of delay, as on cfg_out, keeps bypass and overwrite aligned
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         osc_band_out <= RST_OSC_RESULT;
         osc_bias_out <= RST_OSC_RESULT;
      end else begin
         osc_band_out <= next_osc_band;
         osc_bias_out <= next_osc_bias;
      end
   end

   // zero while reset is held, field defaults one edge after release
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         cfg_out <= '0;
      end else begin
         cfg_out <= next_cfg;
      end
   end

endmodule : rtfc_bank
`default_nettype wire

// >>> sim/rtfc_bank_monitor.sv
// checker: port-level properties of the trim and filter bank
`timescale 1ns/1ns
`default_nettype none
module rtfc_bank_monitor
   import rtfc_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       sys_rst_in,
   input  wire rtfc_req_s  req_in,
   input  wire logic [7:0] rdata_out,
   input  wire logic       rvalid_out,
   input  wire logic       rb_bias_sel_in,
   input  wire rtfc_cal_s  cal_in,
   input  wire logic [5:0] band_ovrw_val_in,
   input  wire logic       band_ovrw_en_in,
   input  wire logic [5:0] bias_ovrw_val_in,
   input  wire logic       bias_ovrw_en_in,
   input  wire logic [5:0] osc_band_out,
   input  wire logic [5:0] osc_bias_out,
   input  wire rtfc_cfg_s  cfg_out
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_wr(a);
      req_in.wr && req_in.addr == a;
   endsequence
   // result latches on done, reaches the outputs one edge later
   sequence s_cal;
      cal_in.done ##2 !cfg_out.cal_bypass;
   endsequence
   property p_rvalid;
      req_in.rd |=> rvalid_out;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   property p_rv_cause;
      rvalid_out |-> $past(req_in.rd);
   endproperty
   a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
   property p_rd_hold;
      !req_in.rd |=> $stable(rdata_out);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_bypass;
      cfg_out.cal_bypass == (cfg_out.cal_skip_code == 4'hf);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass flag wrong");
   property p_cal;
      s_cal |-> osc_band_out == $past(cal_in.band, 2) && osc_bias_out == $past(cal_in.bias, 2);
   endproperty
   a_cal: assert property (p_cal) else $error("calibration result lost");
   property p_ovrw;
      cfg_out.cal_bypass && $past(band_ovrw_en_in) |-> osc_band_out == $past(band_ovrw_val_in);
   endproperty
   a_ovrw: assert property (p_ovrw) else $error("band overwrite not applied");
   property p_ovrw_bias;
      cfg_out.cal_bypass && $past(bias_ovrw_en_in)
         |-> osc_bias_out == $past(bias_ovrw_val_in);
   endproperty
   a_ovrw_bias: assert property (p_ovrw_bias) else $error("bias overwrite not applied");
   property p_skip;
      s_wr(ADDR_CAL_SKIP) |=> ##1 cfg_out.cal_skip_code == $past(req_in.wdata[3:0], 2)
         && cfg_out.cal_bypass == ($past(req_in.wdata[3:0], 2) == CAL_SKIP_BYPASS);
   endproperty
   a_skip: assert property (p_skip) else $error("skip code or bypass wrong");
   property p_decim;
      s_wr(ADDR_RX_DECIM) |=> ##1 {cfg_out.second_stage_decimation,
         cfg_out.first_stage_decimation} == $past(req_in.wdata[4:0], 2);
   endproperty
   a_decim: assert property (p_decim) else $error("decimation fields wrong");
   property p_pd;
      s_wr(ADDR_POST_DEMOD) |=> ##1 cfg_out.post_demod_bw_code == $past(req_in.wdata, 2);
   endproperty
   a_pd: assert property (p_pd) else $error("post demod bandwidth wrong");
   property p_tune;
      s_wr(ADDR_TUNE_HIGH) |=> ##1
         {cfg_out.rx_tune_en, cfg_out.rx_tune_word[8]} == $past(req_in.wdata[1:0], 2);
   endproperty
   a_tune: assert property (p_tune) else $error("tuning high bits wrong");
endmodule : rtfc_bank_monitor

bind rtfc_bank rtfc_bank_monitor rtfc_bank_monitor_i (.*);
`default_nettype wire

// >>> sim/tb.sv
// testbench: defaults, access, calibration readback and overwrite of the trim bank
`timescale 1ns/1ns
`default_nettype none
module tb
   import rtfc_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   rtfc_req_s  req = '0;
   logic       sel = 1'b0;
   rtfc_cal_s  cal = '0;
   logic [5:0] bval = 6'h00;
   logic       ben = 1'b0;
   logic [5:0] ival = 6'h00;
   logic       ien = 1'b0;
   logic [7:0] rdata;
   logic       rvalid;
   logic [5:0] oband;
   logic [5:0] obias;
   rtfc_cfg_s  cfg;
   int         errors = 0;
   int         n_tests = 0;
   logic [9:0] ra [8] = '{ADDR_AMP_BIAS, ADDR_CAL_SKIP, ADDR_XTAL_LOAD, ADDR_RX_DECIM,
                          ADDR_POST_DEMOD, ADDR_TUNE_LOW, ADDR_TUNE_HIGH, ADDR_RX_FE};
   logic [7:0] dv [8] = '{8'h6f, 8'h09, 8'h20, 8'h05, 8'hc8, 8'h00, 8'h08, 8'h1d};
   // reserved bits kept at their defaults in every write value
   logic [7:0] wv [8] = '{8'h7f, 8'h0f, 8'h38, 8'h12, 8'haa, 8'hff, 8'h0b, 8'h16};

   always #5 clk = ~clk;

   rtfc_bank rtfc_bank_i (.sys_clk_in(clk), .sys_rst_in(rst), .req_in(req), .rdata_out(rdata),
      .rvalid_out(rvalid), .rb_bias_sel_in(sel), .cal_in(cal), .band_ovrw_val_in(bval),
      .band_ovrw_en_in(ben), .bias_ovrw_val_in(ival), .bias_ovrw_en_in(ien),
      .osc_band_out(oband), .osc_bias_out(obias), .cfg_out(cfg));

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic s, input logic [7:0] exp);
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= a;
      sel <= s;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk("rvalid", 1'b1, rvalid);
      chk("rdata", exp, rdata);
   endtask : rd
   task automatic t_defaults;
      for (int i = 0; i < 8; i++) rd(ra[i], 1'b0, dv[i]);
      rd(10'h3ff, 1'b0, 8'h00);
      rd(ADDR_OSC_RB, 1'b0, 8'h00);
      rd(ADDR_OSC_RB, 1'b1, 8'h00);
      chk("osc", 12'h000, {oband, obias});
      chk("cfg", {6'h37, 4'h9, 1'b0, 3'h4, 2'h1, 3'h1, 8'hc8, 9'h0, 1'b0, 1'b1, 4'hd}, cfg);
   endtask : t_defaults
   task automatic t_cal;
      @(posedge clk);
      cal <= '{1'b1, 6'h3f, 6'h01};
      @(posedge clk);
      cal.done <= 1'b0;
      rd(ADDR_OSC_RB, 1'b0, 8'hfc);
      rd(ADDR_OSC_RB, 1'b1, 8'h04);
      chk("osc", {6'h3f, 6'h01}, {oband, obias});
   endtask : t_cal
   task automatic t_rw;
      for (int i = 0; i < 8; i++) wr(ra[i], wv[i]);
      wr(10'h3ff, 8'h5a);
      wr(ADDR_OSC_RB, 8'h55);
      for (int i = 0; i < 8; i++) rd(ra[i], 1'b0, wv[i]);
      rd(10'h3ff, 1'b0, 8'h00);
      rd(ADDR_OSC_RB, 1'b0, 8'hfc);
      chk("cfg", {6'h3f, 4'hf, 1'b1, 3'h7, 2'h2, 3'h4, 8'haa, 9'h1ff, 1'b1, 1'b1, 4'h6}, cfg);
      chk("osc", {6'h3f, 6'h01}, {oband, obias});
   endtask : t_rw
   task automatic t_ovrw;
      @(posedge clk);
      bval <= 6'h2a;
      ben <= 1'b1;
      ival <= 6'h15;
      repeat (2) @(posedge clk);
      #1;
      chk("osc", {6'h2a, 6'h01}, {oband, obias});
      wr(ADDR_CAL_SKIP, 8'h09);
      ien <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("osc", {6'h3f, 6'h01}, {oband, obias});
      wr(ADDR_CAL_SKIP, 8'h0f);
      repeat (2) @(posedge clk);
      #1;
      chk("osc", {6'h2a, 6'h15}, {oband, obias});
   endtask : t_ovrw
   task automatic results;
      $display("tests %0d, errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
      t_cal;
      t_rw;
      t_ovrw;
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
      results;
   end
endmodule : tb
`default_nettype wire
